/* rtl/msd_pkg.sv */
// Constants and carrier types of the memory space decoder
package msd_pkg;

	// Program memory
	localparam logic [15:0] CODE_BASE     = 16'h0000;
	localparam logic [15:0] CODE_TOP      = 16'h1DFF;

	// Data spaces
	localparam int          IRAM_BYTES    = 256;
	localparam int          XRAM_BYTES    = 512;
	localparam logic [15:0] XRAM_TOP      = 16'h01FF;
	localparam logic [7:0]  SFR_BASE      = 8'h80;
	localparam logic [7:0]  BIT_BYTE_BASE = 8'h20;
	localparam logic [7:0]  BIT_BYTE_TOP  = 8'h2F;
	localparam logic [7:0]  REG_BANK_TOP  = 8'h1F;

	// Special registers held inside the decoder
	localparam logic [7:0]  STK_ADDR      = 8'h81;
	localparam logic [7:0]  DPTR_LO_ADDR  = 8'h82;
	localparam logic [7:0]  DPTR_HI_ADDR  = 8'h83;
	localparam logic [7:0]  STORE_ADDR    = 8'h8F;
	localparam logic [7:0]  STAT_ADDR     = 8'hD0;

	// Reset values
	localparam logic [7:0]  STK_RESET     = 8'h07;
	localparam logic [7:0]  DP_RESET      = 8'h00;
	localparam logic [7:0]  STORE_RESET   = 8'h00;
	localparam logic [7:0]  STAT_RESET    = 8'h00;

	// Field positions
	localparam int          STORE_WEN_BIT = 0;
	localparam int          BANK_SEL_LOW  = 3;
	localparam int          BANK_SEL_HIGH = 4;

	// Access kinds, given by the instruction type
	typedef enum logic [2:0] {
		K_CODE     = 3'h0,
		K_DIRECT   = 3'h1,
		K_INDIRECT = 3'h2,
		K_REG      = 3'h3,
		K_BIT      = 3'h4,
		K_EXT      = 3'h5,
		K_PUSH     = 3'h6,
		K_POP      = 3'h7
	} msd_kind_t;

	typedef enum logic [2:0] {
		T_IRAM = 3'h0,
		T_SFR  = 3'h1,
		T_XRAM = 3'h2,
		T_CODE = 3'h3,
		T_NONE = 3'h4
	} msd_tgt_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_PTR  = 4'b0010,
		ST_ADDR = 4'b0100,
		ST_WAIT = 4'b1000
	} msd_state_t;

	typedef struct packed {
		msd_kind_t   kind;
		logic        write;
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wbit;
	} msd_req_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       bit_val;
		logic       reserved;
	} msd_rsp_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        rd;
		logic        wr;
		logic [7:0]  wdata;
	} msd_code_t;

	typedef struct packed {
		logic [7:0] addr;
		logic       rd;
		logic       wr;
		logic [7:0] wdata;
	} msd_sfr_t;

endpackage

/* rtl/msd_ram.sv */
// Single-port byte RAM with registered read data
`timescale 1ns/1ps
`default_nettype none
module msd_ram #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 256,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             clk,
	input  wire logic             we,
	input  wire logic             re,
	input  wire logic [AW-1:0]    addr,
	input  wire logic [WIDTH-1:0] wdata,
	output var  logic [WIDTH-1:0] rdata
);

	logic [WIDTH-1:0] mem [DEPTH];

	// No reset on the array: contents are undefined until written
	always_ff @(posedge clk)
	begin
		if (we)
		begin
			mem[addr] <= wdata;
		end
		if (re)
		begin
			rdata <= mem[addr];
		end
	end

endmodule
`default_nettype wire

/* rtl/msd_top.sv */
// Memory space decoder: program, internal, special and external data
//
// Overview of operation
// (R01) Program memory spans 0x0000 to 0x1DFF; higher program addresses reserved.
// (R02) Program memory read-only, except external writes while store enable set; code-kind write requests also write it, with no store enable check.
// (R03) Internal data RAM holds 256 bytes at data addresses 0x00 to 0xFF.
// (R04) Lower 128 internal bytes reachable by direct and indirect access.
// (R05) Above 0x7F, indirect goes to upper RAM, direct goes to registers.
// (R06) 512 bytes of external data RAM, reached only by external moves.
// (R07) Bytes 0x00 to 0x1F form four banks of eight registers, one active.
// (R08) Status word bits 3 and 4 select the active register bank.
// (R09) Registers zero and one of active bank serve as indirect pointers.
// (R10) Bytes 0x20 to 0x2F give 128 bits; bit address is 8*offset+bit.
// (R11) Bit or byte access decided only by the instruction operand type.
// (R12) Stack pointer marks last used slot; push increments the pointer, then writes the new slot.
// (R13) Stack pointer lives at 0x81 and resets to 0x07.
// (R14) Stack may lie anywhere in the 256 bytes, full depth.
// (R15) Direct accesses to 0x80 through 0xFF go to special registers.
// (R16) Registers at low nibble 0x0 or 0x8 are also bit addressable.
// (R17) Software must avoid unoccupied special register addresses.
// (R18) Program and data spaces told apart by instruction type.
// (R19) Pop reads the slot at the pointer, then decrements the pointer.
`timescale 1ns/1ps
`default_nettype none
module msd_top (
	input  wire logic              mclk,
	input  wire logic              reset_n,
	input  wire logic              req_valid,
	input  wire msd_pkg::msd_req_t req,
	output var  logic              req_ready,
	output var  msd_pkg::msd_rsp_t rsp,
	output var  msd_pkg::msd_code_t code_bus,
	input  wire logic [7:0]        code_rdata,
	output var  msd_pkg::msd_sfr_t sfr_bus,
	input  wire logic [7:0]        sfr_rdata,
	output var  logic [7:0]        stack_pointer,
	output var  logic [15:0]       data_pointer,
	output var  logic [7:0]        program_status_word,
	output var  logic [7:0]        program_store_control
);

	typedef struct packed {
		msd_pkg::msd_state_t state;
		msd_pkg::msd_req_t   req;
		logic [7:0]          eff;
		msd_pkg::msd_tgt_t   tgt;
		logic                rdy;
		logic [7:0]          stk;
		logic [7:0]          dp_lo;
		logic [7:0]          dp_hi;
		logic [7:0]          pstore;
		logic [7:0]          status;
		msd_pkg::msd_rsp_t   rsp;
		msd_pkg::msd_code_t  code;
		msd_pkg::msd_sfr_t   sfr;
	} msd_regs_t;

	logic [1:0] rst_sync_reg;
	logic       rst_n;
	msd_regs_t  r_reg;
	msd_regs_t  r_next;

	logic       iram_we;
	logic       iram_re;
	logic [7:0] iram_a;
	logic [7:0] iram_d;
	logic [7:0] iram_q;
	logic       xram_we;
	logic       xram_re;
	logic [8:0] xram_a;
	logic [7:0] xram_q;
	logic       acc;

	// Byte holding a bit: low bits map into 0x20..0x2F, high ones to registers
	function automatic logic [7:0] bit_byte(input logic [7:0] b);
		if (b[7])
			return {b[7:3], 3'b000}; // (R16)
		return msd_pkg::BIT_BYTE_BASE + {4'h0, b[6:3]}; // (R10)
	endfunction

	function automatic logic is_int_sfr(input logic [7:0] a);
		return a == msd_pkg::STK_ADDR || a == msd_pkg::DPTR_LO_ADDR ||
			a == msd_pkg::DPTR_HI_ADDR || a == msd_pkg::STORE_ADDR ||
			a == msd_pkg::STAT_ADDR;
	endfunction

	function automatic msd_pkg::msd_tgt_t tgt_of(input msd_pkg::msd_req_t q,
		input logic wen);
		case (q.kind)
			msd_pkg::K_CODE:
				return q.addr > msd_pkg::CODE_TOP ? msd_pkg::T_NONE
					: msd_pkg::T_CODE; // (R01)
			msd_pkg::K_DIRECT, msd_pkg::K_BIT:
				return q.addr[7] ? msd_pkg::T_SFR : msd_pkg::T_IRAM; // (R15)
			msd_pkg::K_EXT:
			begin
				if (q.write && wen)
					return q.addr > msd_pkg::CODE_TOP ? msd_pkg::T_NONE
						: msd_pkg::T_CODE; // (R02)
				return q.addr > msd_pkg::XRAM_TOP ? msd_pkg::T_NONE
					: msd_pkg::T_XRAM; // (R06)
			end
			default:
				return msd_pkg::T_IRAM;
		endcase
	endfunction

	// Reset is released through two flops so every flop of r_reg leaves reset together
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			rst_sync_reg <= 2'b00;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	assign acc = (r_reg.state == msd_pkg::ST_IDLE) && r_reg.rdy && req_valid;

	always_comb
	begin
		logic       w_sfr;
		logic [7:0] w_val;
		logic [7:0] v;
		logic [7:0] nb;
		logic       finish;
		w_sfr = 1'b0;
		w_val = 8'h00;
		v = 8'h00;
		nb = 8'h00;
		finish = 1'b0;
		r_next = r_reg;
		r_next.rsp.valid = 1'b0;
		r_next.code.rd = 1'b0;
		r_next.code.wr = 1'b0;
		r_next.sfr.rd = 1'b0;
		r_next.sfr.wr = 1'b0;
		iram_we = 1'b0;
		iram_re = 1'b0;
		iram_a = r_reg.eff;
		iram_d = r_reg.req.wdata;
		xram_we = 1'b0;
		xram_re = 1'b0;
		xram_a = r_reg.req.addr[8:0];
		case (r_reg.state)
			msd_pkg::ST_IDLE:
			begin
				if (acc)
				begin
					r_next.req = req;
					r_next.rdy = 1'b0;
					r_next.tgt = tgt_of(req, r_reg.pstore[msd_pkg::STORE_WEN_BIT]);
					r_next.state = msd_pkg::ST_ADDR;
					case (req.kind)
						msd_pkg::K_INDIRECT:
						begin
							iram_re = 1'b1;
							iram_a = {3'b000, r_reg.status[msd_pkg::BANK_SEL_HIGH:
								msd_pkg::BANK_SEL_LOW], 2'b00, req.addr[0]}; // (R09)
							r_next.state = msd_pkg::ST_PTR;
						end
						msd_pkg::K_PUSH:
						begin
							r_next.eff = r_reg.stk + 8'h01; // (R12)
							r_next.stk = r_reg.stk + 8'h01; // (R12)
							r_next.req.write = 1'b1;
						end
						msd_pkg::K_POP:
						begin
							r_next.eff = r_reg.stk; // (R19)
							r_next.stk = r_reg.stk - 8'h01; // (R19)
							r_next.req.write = 1'b0;
						end
						msd_pkg::K_REG:
							r_next.eff = {3'b000, r_reg.status[msd_pkg::BANK_SEL_HIGH:
								msd_pkg::BANK_SEL_LOW], req.addr[2:0]}; // (R07) (R08)
						msd_pkg::K_BIT:
							r_next.eff = bit_byte(req.addr[7:0]); // (R10)
						default:
							r_next.eff = req.addr[7:0]; // (R04)
					endcase
				end
			end
			msd_pkg::ST_PTR:
			begin
				// Pointer byte addresses the full 256 bytes, never registers
				r_next.eff = iram_q; // (R05)
				r_next.tgt = msd_pkg::T_IRAM; // (R05)
				r_next.state = msd_pkg::ST_ADDR;
			end
			msd_pkg::ST_ADDR:
			begin
				// Bit writes take a read first and merge in the wait state
				r_next.state = msd_pkg::ST_WAIT;
				case (r_reg.tgt)
					msd_pkg::T_IRAM:
					begin
						if (r_reg.req.write && r_reg.req.kind != msd_pkg::K_BIT)
						begin
							iram_we = 1'b1; // (R03) (R14)
							finish = 1'b1;
						end
						else
							iram_re = 1'b1;
					end
					msd_pkg::T_XRAM:
					begin
						if (r_reg.req.write)
						begin
							xram_we = 1'b1; // (R06)
							finish = 1'b1;
						end
						else
							xram_re = 1'b1;
					end
					msd_pkg::T_SFR:
					begin
						if (r_reg.req.write && r_reg.req.kind != msd_pkg::K_BIT)
						begin
							w_sfr = 1'b1;
							w_val = r_reg.req.wdata;
							finish = 1'b1;
						end
						else if (!is_int_sfr(r_reg.eff))
						begin
							r_next.sfr.addr = r_reg.eff; // (R15)
							r_next.sfr.rd = 1'b1;
						end
					end
					msd_pkg::T_CODE:
					begin
						r_next.code.addr = r_reg.req.addr;
						r_next.code.wdata = r_reg.req.wdata;
						if (r_reg.req.write)
						begin
							r_next.code.wr = 1'b1; // (R02)
							finish = 1'b1;
						end
						else
							r_next.code.rd = 1'b1; // (R18)
					end
					default:
					begin
						r_next.rsp.reserved = 1'b1; // (R01)
						r_next.rsp.data = 8'h00;
						finish = 1'b1;
					end
				endcase
			end
			msd_pkg::ST_WAIT:
			begin
				case (r_reg.tgt)
					msd_pkg::T_IRAM:
						v = iram_q;
					msd_pkg::T_XRAM:
						v = xram_q;
					msd_pkg::T_CODE:
						v = code_rdata;
					default:
					begin
						if (r_reg.eff == msd_pkg::STK_ADDR)
							v = r_reg.stk;
						else if (r_reg.eff == msd_pkg::DPTR_LO_ADDR)
							v = r_reg.dp_lo;
						else if (r_reg.eff == msd_pkg::DPTR_HI_ADDR)
							v = r_reg.dp_hi;
						else if (r_reg.eff == msd_pkg::STORE_ADDR)
							v = r_reg.pstore;
						else if (r_reg.eff == msd_pkg::STAT_ADDR)
							v = r_reg.status;
						else
							v = sfr_rdata;
					end
				endcase
				nb = v;
				nb[r_reg.req.addr[2:0]] = r_reg.req.wbit;
				if (r_reg.req.kind == msd_pkg::K_BIT && r_reg.req.write)
				begin
					// Read-modify-write keeps the other seven bits intact
					if (r_reg.tgt == msd_pkg::T_IRAM)
					begin
						iram_we = 1'b1; // (R11)
						iram_d = nb;
					end
					else
					begin
						w_sfr = 1'b1; // (R11)
						w_val = nb;
					end
				end
				r_next.rsp.data = v;
				r_next.rsp.bit_val = v[r_reg.req.addr[2:0]]; // (R11)
				finish = 1'b1;
			end
			default:
				r_next.state = msd_pkg::ST_IDLE;
		endcase
		if (w_sfr)
		begin
			if (r_reg.eff == msd_pkg::STK_ADDR)
				r_next.stk = w_val; // (R13)
			else if (r_reg.eff == msd_pkg::DPTR_LO_ADDR)
				r_next.dp_lo = w_val;
			else if (r_reg.eff == msd_pkg::DPTR_HI_ADDR)
				r_next.dp_hi = w_val;
			else if (r_reg.eff == msd_pkg::STORE_ADDR)
				r_next.pstore = w_val;
			else if (r_reg.eff == msd_pkg::STAT_ADDR)
				r_next.status = w_val;
			else
			begin
				r_next.sfr.addr = r_reg.eff; // (R15)
				r_next.sfr.wdata = w_val;
				r_next.sfr.wr = 1'b1;
			end
		end
		if (finish)
		begin
			r_next.rsp.valid = 1'b1;
			r_next.rdy = 1'b1;
			r_next.state = msd_pkg::ST_IDLE;
		end
		if (acc)
			r_next.rsp.reserved = 1'b0;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r_reg <= '0;
			r_reg.state <= msd_pkg::ST_IDLE;
			r_reg.rdy <= 1'b1;
			r_reg.stk <= msd_pkg::STK_RESET; // (R13)
			r_reg.dp_lo <= msd_pkg::DP_RESET;
			r_reg.dp_hi <= msd_pkg::DP_RESET;
			r_reg.pstore <= msd_pkg::STORE_RESET;
			r_reg.status <= msd_pkg::STAT_RESET;
		end
		else
			r_reg <= r_next;
	end

	msd_ram #(
		.WIDTH (8),
		.DEPTH (msd_pkg::IRAM_BYTES)
	) u_iram (
		.clk   (mclk),
		.we    (iram_we),
		.re    (iram_re),
		.addr  (iram_a),
		.wdata (iram_d),
		.rdata (iram_q)
	);

	msd_ram #(
		.WIDTH (8),
		.DEPTH (msd_pkg::XRAM_BYTES)
	) u_xram (
		.clk   (mclk),
		.we    (xram_we),
		.re    (xram_re),
		.addr  (xram_a),
		.wdata (r_reg.req.wdata),
		.rdata (xram_q)
	);

	assign req_ready = r_reg.rdy;
	assign rsp = r_reg.rsp;
	assign code_bus = r_reg.code;
	assign sfr_bus = r_reg.sfr;
	assign stack_pointer = r_reg.stk;
	assign data_pointer = {r_reg.dp_hi, r_reg.dp_lo};
	assign program_status_word = r_reg.status;
	assign program_store_control = r_reg.pstore;

	sequence s_push;
		acc && req.kind == msd_pkg::K_PUSH;
	endsequence
	sequence s_pop;
		acc && req.kind == msd_pkg::K_POP;
	endsequence
	sequence s_answer;
		##[2:4] r_reg.rsp.valid;
	endsequence

	property p_push;
		@(posedge mclk) disable iff (!rst_n)
		s_push |=> r_reg.stk == $past(r_reg.stk) + 8'h01 ##0
			(iram_we && iram_a == r_reg.stk);
	endproperty
	a_push: assert property (p_push) else $error("push order wrong"); // (R12)

	property p_pop;
		@(posedge mclk) disable iff (!rst_n)
		s_pop |=> iram_re && iram_a == r_reg.stk + 8'h01;
	endproperty
	a_pop: assert property (p_pop) else $error("pop order wrong"); // (R19)

	property p_stk_reset;
		@(posedge mclk) $rose(rst_n) |-> r_reg.stk == msd_pkg::STK_RESET;
	endproperty
	a_stk_reset: assert property (p_stk_reset) else $error("stack reset"); // (R13)

	property p_code_range;
		@(posedge mclk) disable iff (!rst_n)
		r_reg.code.rd || r_reg.code.wr |-> r_reg.code.addr <= msd_pkg::CODE_TOP;
	endproperty
	a_code_range: assert property (p_code_range) else $error("code range"); // (R01)

	property p_code_wen;
		@(posedge mclk) disable iff (!rst_n)
		r_reg.code.wr |-> r_reg.pstore[msd_pkg::STORE_WEN_BIT]
			&& r_reg.req.kind == msd_pkg::K_EXT;
	endproperty
	a_code_wen: assert property (p_code_wen) else $error("code write"); // (R02)

	property p_sfr_direct;
		@(posedge mclk) disable iff (!rst_n)
		r_reg.sfr.rd || r_reg.sfr.wr |-> r_reg.sfr.addr[7]
			&& r_reg.req.kind inside {msd_pkg::K_DIRECT, msd_pkg::K_BIT};
	endproperty
	a_sfr_direct: assert property (p_sfr_direct) else $error("sfr route"); // (R15)

	property p_sfr_bit;
		@(posedge mclk) disable iff (!rst_n)
		(r_reg.sfr.rd || r_reg.sfr.wr) && r_reg.req.kind == msd_pkg::K_BIT
			|-> r_reg.sfr.addr[2:0] == 3'h0;
	endproperty
	a_sfr_bit: assert property (p_sfr_bit) else $error("sfr bit addr"); // (R16)

	property p_bank;
		@(posedge mclk) disable iff (!rst_n)
		r_reg.state == msd_pkg::ST_ADDR && r_reg.req.kind == msd_pkg::K_REG
			|-> (iram_we || iram_re) && iram_a == {3'b000,
			r_reg.status[msd_pkg::BANK_SEL_HIGH:msd_pkg::BANK_SEL_LOW],
			r_reg.req.addr[2:0]};
	endproperty
	a_bank: assert property (p_bank) else $error("bank select"); // (R08)

	property p_indirect;
		@(posedge mclk) disable iff (!rst_n)
		r_reg.state == msd_pkg::ST_ADDR && r_reg.req.kind == msd_pkg::K_INDIRECT
			|-> r_reg.tgt == msd_pkg::T_IRAM && !r_next.sfr.rd;
	endproperty
	a_indirect: assert property (p_indirect) else $error("indirect route"); // (R05)

	property p_xram;
		@(posedge mclk) disable iff (!rst_n)
		xram_we || xram_re |-> r_reg.req.kind == msd_pkg::K_EXT;
	endproperty
	a_xram: assert property (p_xram) else $error("xram kind"); // (R06)

	property p_answer;
		@(posedge mclk) disable iff (!rst_n)
		acc |-> s_answer;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer"); // (R18)

endmodule
`default_nettype wire

/* verification/msd_far_model.sv */
// Far-side model: program store and peripheral special registers
`timescale 1ns/1ps
`default_nettype none
module msd_far_model (
	input  wire logic               mclk,
	input  wire msd_pkg::msd_code_t code_bus,
	output var  logic [7:0]         code_rdata,
	input  wire msd_pkg::msd_sfr_t  sfr_bus,
	output var  logic [7:0]         sfr_rdata
);
	logic [7:0] cmem [0:8191];
	logic [7:0] smem [0:127];
	logic [7:0] c_last;
	logic [7:0] s_last;
	initial
	begin
		for (int i = 0; i < 8192; i++)
			cmem[i] = 8'(i) ^ 8'h5A;
		for (int i = 0; i < 128; i++)
			smem[i] = {1'b1, 7'(i)} ^ 8'h3C;
		c_last = 8'h00;
		s_last = 8'h00;
	end
	// Outside a read strobe show the inverse of the last byte, never a copy
	assign code_rdata = code_bus.rd ? cmem[code_bus.addr[12:0]] : ~c_last;
	assign sfr_rdata = sfr_bus.rd ? smem[sfr_bus.addr[6:0]] : ~s_last;
	always @(posedge mclk)
	begin
		if (code_bus.rd)
			c_last <= cmem[code_bus.addr[12:0]];
		if (code_bus.wr)
			cmem[code_bus.addr[12:0]] <= code_bus.wdata;
		if (sfr_bus.rd)
			s_last <= smem[sfr_bus.addr[6:0]];
		if (sfr_bus.wr)
			smem[sfr_bus.addr[6:0]] <= sfr_bus.wdata;
	end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench of the memory space decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {
		logic [7:0] d;
		logic       b;
		logic       r;
		logic       cd;
		logic       cb;
	} tb_note_t;
	logic               mclk;
	logic               reset_n;
	logic               req_valid;
	msd_pkg::msd_req_t  req;
	logic               req_ready;
	msd_pkg::msd_rsp_t  rsp;
	msd_pkg::msd_code_t code_bus;
	msd_pkg::msd_sfr_t  sfr_bus;
	logic [7:0]         code_rdata;
	logic [7:0]         sfr_rdata;
	logic [7:0]         stack_pointer;
	logic [15:0]        data_pointer;
	logic [7:0]         program_status_word;
	logic [7:0]         program_store_control;
	tb_note_t           notes [$];
	tb_note_t           n;
	int                 num_errors;
	int                 total_checks;
	int                 cycles;
	logic [7:0]         v0;
	logic [7:0]         v;
	logic [7:0]         a;
	logic [7:0]         spat;

	msd_top msd_top_inst (.mclk(mclk), .reset_n(reset_n),
		.req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp(rsp),
		.code_bus(code_bus), .code_rdata(code_rdata), .sfr_bus(sfr_bus),
		.sfr_rdata(sfr_rdata), .stack_pointer(stack_pointer),
		.data_pointer(data_pointer), .program_status_word(program_status_word),
		.program_store_control(program_store_control));
	msd_far_model msd_far_model_inst (.mclk(mclk), .code_bus(code_bus),
		.code_rdata(code_rdata), .sfr_bus(sfr_bus), .sfr_rdata(sfr_rdata));

	always #5 mclk = ~mclk;

	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic cmp1(input logic got, input logic exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask

	function automatic tb_note_t nd(input logic [7:0] d);
		return '{d, 1'b0, 1'b0, 1'b1, 1'b0};
	endfunction
	function automatic tb_note_t nb(input logic b);
		return '{8'h00, b, 1'b0, 1'b0, 1'b1};
	endfunction
	localparam tb_note_t NW = '{8'h00, 1'b0, 1'b0, 1'b0, 1'b0};
	localparam tb_note_t NR = '{8'h00, 1'b0, 1'b1, 1'b1, 1'b0};

	// Holds the request until the edge that takes it; caller is on a rise
	task automatic op(input msd_pkg::msd_kind_t k, input logic w,
		input logic [15:0] ad, input logic [7:0] wd, input logic wb,
		input tb_note_t nt);
		int g;
		req_valid <= 1'b1;
		req <= '{kind: k, write: w, addr: ad, wdata: wd, wbit: wb};
		g = 0;
		@(negedge mclk);
		while (req_ready !== 1'b1 && g < 20)
		begin
			@(negedge mclk);
			g++;
		end
		if (g >= 20)
		begin
			num_errors++;
			$display("BAD t=%0t request never taken", $time);
		end
		@(posedge mclk);
		notes.push_back(nt);
	endtask

	task automatic wr(input msd_pkg::msd_kind_t k, input logic [15:0] ad,
		input logic [7:0] d);
		op(k, 1'b1, ad, d, 1'b0, NW);
	endtask
	task automatic rd(input msd_pkg::msd_kind_t k, input logic [15:0] ad,
		input logic [7:0] d);
		op(k, 1'b0, ad, 8'h00, 1'b0, nd(d));
	endtask

	// Drop the request so a stale one is not taken again, then settle
	task automatic drain(input string name);
		int g;
		req_valid <= 1'b0;
		g = 0;
		while ((notes.size() != 0 || req_ready !== 1'b1) && g < 20)
		begin
			@(negedge mclk);
			g++;
		end
		cmp1(notes.size() == 0, 1'b1, "response missing");
		$display("test %s done", name);
		@(posedge mclk);
	endtask

	always @(negedge mclk)
	begin
		if (reset_n && rsp.valid === 1'b1)
		begin
			if (notes.size() == 0)
			begin
				num_errors++;
				$display("BAD t=%0t unexpected response", $time);
			end
			else
			begin
				n = notes.pop_front();
				cmp1(rsp.reserved, n.r, "reserved");
				if (n.cd)
					cmp8(rsp.data, n.d, "data");
				if (n.cb)
					cmp1(rsp.bit_val, n.b, "bit");
			end
		end
	end

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			$display("BAD t=%0t timeout", $time);
			close_out();
		end
	end

	initial
	begin
		mclk = 1'b0;
		reset_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		v = $urandom(32'h4dc81907);
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		cmp8(stack_pointer, 8'h07, "stack reset");
		cmp8(data_pointer[7:0] | data_pointer[15:8], 8'h00, "pointer reset");
		cmp8(program_status_word, 8'h00, "status reset");
		cmp8(program_store_control, 8'h00, "store ctl reset");
		cmp1(req_ready, 1'b1, "ready reset");
		@(posedge mclk);
		v0 = 8'($urandom);
		wr(msd_pkg::K_DIRECT, 16'h0030, v0);
		wr(msd_pkg::K_DIRECT, 16'h0000, 8'h30);
		rd(msd_pkg::K_INDIRECT, 16'h0000, v0);
		wr(msd_pkg::K_DIRECT, 16'h0001, 8'h90);
		wr(msd_pkg::K_INDIRECT, 16'h0001, ~v0);
		rd(msd_pkg::K_INDIRECT, 16'h0001, ~v0);
		// Peripheral latch address is occupied, so the read is defined
		rd(msd_pkg::K_DIRECT, 16'h0090, 8'h90 ^ 8'h3C);
		rd(msd_pkg::K_DIRECT, 16'h0081, 8'h07);
		wr(msd_pkg::K_DIRECT, 16'h0082, v0);
		wr(msd_pkg::K_DIRECT, 16'h0083, ~v0);
		rd(msd_pkg::K_DIRECT, 16'h0083, ~v0);
		wr(msd_pkg::K_DIRECT, 16'h0090, 8'hA5);
		op(msd_pkg::K_BIT, 1'b1, 16'h0092, 8'h00, 1'b0, NW);
		rd(msd_pkg::K_DIRECT, 16'h0090, 8'hA1);
		drain("ram");
		cmp8(data_pointer[15:8], ~v0, "pointer high");
		cmp8(data_pointer[7:0], v0, "pointer low");
		for (int b = 0; b < 4; b++)
		begin
			wr(msd_pkg::K_DIRECT, 16'h00D0, 8'(b << 3));
			wr(msd_pkg::K_REG, 16'h0002, 8'hC0 + 8'(b));
		end
		for (int b = 0; b < 4; b++)
			rd(msd_pkg::K_DIRECT, 16'(8 * b + 2), 8'hC0 + 8'(b));
		drain("banks");
		cmp8(program_status_word, 8'h18, "status");
		wr(msd_pkg::K_DIRECT, 16'h00D0, 8'h00);
		wr(msd_pkg::K_DIRECT, 16'h0022, 8'h00);
		op(msd_pkg::K_BIT, 1'b1, 16'h0013, 8'h00, 1'b1, NW);
		rd(msd_pkg::K_DIRECT, 16'h0022, 8'h08);
		op(msd_pkg::K_BIT, 1'b0, 16'h0013, 8'h00, 1'b0, nb(1'b1));
		op(msd_pkg::K_BIT, 1'b0, 16'h0014, 8'h00, 1'b0, nb(1'b0));
		spat = 8'h80 ^ 8'h3C;
		op(msd_pkg::K_BIT, 1'b0, 16'h0083, 8'h00, 1'b0, nb(spat[3]));
		op(msd_pkg::K_BIT, 1'b1, 16'h00D3, 8'h00, 1'b1, NW);
		rd(msd_pkg::K_DIRECT, 16'h00D0, 8'h08);
		op(msd_pkg::K_BIT, 1'b1, 16'h00D3, 8'h00, 1'b0, NW);
		drain("bits");
		v = 8'($urandom);
		op(msd_pkg::K_PUSH, 1'b0, 16'h0000, v, 1'b0, NW);
		drain("push");
		cmp8(stack_pointer, 8'h08, "stack push");
		rd(msd_pkg::K_DIRECT, 16'h0008, v);
		op(msd_pkg::K_POP, 1'b0, 16'h0000, 8'h00, 1'b0, nd(v));
		drain("pop");
		cmp8(stack_pointer, 8'h07, "stack pop");
		wr(msd_pkg::K_DIRECT, 16'h0081, 8'hFE);
		op(msd_pkg::K_PUSH, 1'b0, 16'h0000, 8'h5C, 1'b0, NW);
		wr(msd_pkg::K_DIRECT, 16'h0001, 8'hFF);
		rd(msd_pkg::K_INDIRECT, 16'h0001, 8'h5C);
		drain("deep stack");
		cmp8(stack_pointer, 8'hFF, "stack top");
		wr(msd_pkg::K_EXT, 16'h01FF, v);
		wr(msd_pkg::K_EXT, 16'h0030, 8'h11);
		rd(msd_pkg::K_EXT, 16'h01FF, v);
		rd(msd_pkg::K_DIRECT, 16'h0030, v0);
		op(msd_pkg::K_EXT, 1'b0, 16'h0200, 8'h00, 1'b0, NR);
		rd(msd_pkg::K_CODE, 16'h1DFF, 8'hFF ^ 8'h5A);
		op(msd_pkg::K_CODE, 1'b0, 16'h1E00, 8'h00, 1'b0, NR);
		wr(msd_pkg::K_EXT, 16'h0100, 8'h77);
		rd(msd_pkg::K_CODE, 16'h0100, 8'h00 ^ 8'h5A);
		wr(msd_pkg::K_DIRECT, 16'h008F, 8'h01);
		wr(msd_pkg::K_EXT, 16'h0100, 8'h66);
		op(msd_pkg::K_EXT, 1'b1, 16'h1E00, 8'h33, 1'b0, NR);
		rd(msd_pkg::K_CODE, 16'h0100, 8'h66);
		rd(msd_pkg::K_EXT, 16'h0100, 8'h77);
		drain("spaces");
		cmp8(program_store_control, 8'h01, "store ctl");
		repeat (8)
		begin
			a = 8'h40 + 8'($urandom % 64);
			v = 8'($urandom);
			wr(msd_pkg::K_DIRECT, {8'h00, a}, v);
			rd(msd_pkg::K_DIRECT, {8'h00, a}, v);
		end
		drain("random");
		close_out();
	end
endmodule
`default_nettype wire
